// *** hdl/sltp_ctrl.sv ***
// Lane test pattern control and lane diagnostic register logic.
// Assumes checkers, link state machines and generators on the same clock;
// the register port is a simple synchronous read/write strobe interface.
// Behaviour
// - Held quiet in Detect.Quiet: receiver termination on, serdes P0.
// - Quiet bit clear: link state machine leaves Detect.Quiet normally.
// - Quiet bit set: keep state machine in Detect.Quiet, now or later.
// - Quiet port may send PRBS or user pattern without loopback.
// - Rate bit 0 selects 2.5 GT/s, 1 selects 5.0 GT/s.
// - Manual rate applies only while the port's quiet bit is set.
// - No bypass: repeat alignment until a checker sees it, then sync.
// - Bypass set: one alignment, one sync, then the user pattern.
// - Bypass bits 31:28; port 0 accepts either serdes, others own.
// - On user pattern mismatch show the expected byte in bits 7:0.
// - On user pattern mismatch show the received byte in bits 15:8.
// - Eight bit error counter at 23:16 saturates at 255.
// - Error counter clears when its checker mode is disabled.
// - Lane select 25:24 picks the lane shown in bits 30 and 23:0.
// - Bit 30 shows counter source: 0 user pattern, 1 PRBS.
// - Disable bit keeps port quiet, no idle sets, serdes in P1.
`timescale 1ns/10ps
module sltp_ctrl #(
    parameter int NPORT = sltp_pkg::NUM_PORTS,
    parameter int NLANE = sltp_pkg::NUM_LANES
) (
    input  wire logic                       CLK,
    input  wire logic                       RST_N,
    input  wire logic                       CE,
    input  wire logic                       REG_WR,
    input  wire logic                       REG_RD,
    input  wire logic [11:0]                REG_ADDR,
    input  wire logic [31:0]                REG_WDATA,
    output logic      [31:0]                REG_RDATA,
    input  wire logic [15:0]                SKIP_CTRL_LO,
    input  wire logic [NPORT-1:0]           IN_DETECT_QUIET,
    input  wire logic [NLANE-1:0]           UTP_EN,
    input  wire logic [NLANE-1:0]           PRBS_EN,
    input  wire sltp_pkg::sltp_chk_s [NLANE-1:0] CHK,
    output sltp_pkg::sltp_port_s [NPORT-1:0] PORT_CTRL,
    output logic [NPORT-1:0][8:0]           TX_SYM,
    output logic [NPORT-1:0]                TX_USER
);
    // Register state.
    logic [NPORT-1:0]           dis, quiet, rate, skip;
    logic [NPORT-1:0]           next_dis, next_quiet, next_rate, next_skip;
    logic [1:0]                 sel, next_sel;
    logic [NLANE-1:0][7:0]      cnt, next_cnt, exp_b, next_exp, rcv_b;
    logic [NLANE-1:0][7:0]      next_rcv;
    logic [NLANE-1:0]           src, next_src;
    logic [31:0]                next_rdata;
    sltp_pkg::sltp_tx_e [NPORT-1:0] tx_st, next_tx_st;
    logic [NPORT-1:0][1:0]      idx, next_idx;
    sltp_pkg::sltp_port_s [NPORT-1:0] next_port;
    logic [NPORT-1:0][8:0]      next_sym;
    logic [NPORT-1:0]           next_user;
    logic [NPORT-1:0]           aseen, next_aseen; // Report held in ALIGN.

    // Alignment sequence symbol by index.
    function automatic logic [8:0] align_sym(input logic [1:0] i);
        case (i)
            2'h0:    align_sym = sltp_pkg::SYM_D3_2;
            2'h1:    align_sym = sltp_pkg::SYM_D18_2;
            2'h2:    align_sym = sltp_pkg::SYM_D13_2;
            default: align_sym = sltp_pkg::SYM_D17_1;
        endcase
    endfunction

    // Sync sequence symbol by index.
    function automatic logic [8:0] sync_sym(input logic [1:0] i);
        case (i)
            2'h0:    sync_sym = sltp_pkg::SYM_K28_5;
            2'h1:    sync_sym = sltp_pkg::SYM_D3_2;
            2'h2:    sync_sym = sltp_pkg::SYM_D18_2;
            default: sync_sym = sltp_pkg::SYM_D13_2;
        endcase
    endfunction

    // Decode register writes for the control fields.
    always_comb begin
        next_dis   = dis;
        next_quiet = quiet;
        next_rate  = rate;
        next_skip  = skip;
        next_sel   = sel;
        if (REG_WR && REG_ADDR == sltp_pkg::OFF_PORT_CTRL) begin
            next_dis   = REG_WDATA[sltp_pkg::POS_DISABLE +: 4];
            next_quiet = REG_WDATA[sltp_pkg::POS_QUIET +: 4];
            next_rate  = REG_WDATA[sltp_pkg::POS_RATE +: 4];
            next_skip  = REG_WDATA[sltp_pkg::POS_SKIP_ALIGN +: 4];
        end
        if (REG_WR && REG_ADDR == sltp_pkg::OFF_LANE_DIAG) begin
            next_sel = REG_WDATA[sltp_pkg::POS_SEL +: 2];
        end
    end

    // Per-lane capture and error counting.
    always_comb begin
        for (int l = 0; l < NLANE; l++) begin
            next_exp[l] = exp_b[l];
            next_rcv[l] = rcv_b[l];
            next_cnt[l] = cnt[l];
            next_src[l] = PRBS_EN[l] & ~UTP_EN[l];
            if (!UTP_EN[l] && !PRBS_EN[l]) begin
                next_cnt[l] = 8'h00;
            end else if ((UTP_EN[l] && CHK[l].utp_err) ||
                         (PRBS_EN[l] && CHK[l].prbs_err)) begin
                if (cnt[l] != sltp_pkg::CNT_MAX)
                    next_cnt[l] = cnt[l] + 8'h01;
            end
            // Hold bytes until mismatch or disable.
            if (!UTP_EN[l]) begin
                next_exp[l] = 8'h00;
                next_rcv[l] = 8'h00;
            end else if (CHK[l].utp_err) begin
                next_exp[l] = CHK[l].exp_byte;
                next_rcv[l] = CHK[l].rcv_byte;
            end
        end
    end

    // Port control and user pattern transmitter sequencing.
    always_comb begin
        for (int p = 0; p < NPORT; p++) begin
            logic seen;
            seen = 1'b0;
            // Port 0 takes either serdes, others their own.
            seen = (p == 0) ? (CHK[0].align_seen | CHK[1].align_seen)
                            : CHK[p].align_seen;
            next_tx_st[p] = tx_st[p];
            next_idx[p]   = idx[p] + 2'h1;
            next_sym[p]   = 9'h0_00;
            next_user[p]  = 1'b0;
            next_aseen[p] = 1'b0;
            next_port[p].hold_quiet = quiet[p] | dis[p];
            next_port[p].no_eios    = dis[p];
            next_port[p].rx_term    = 1'b0;
            next_port[p].pwr_state  = sltp_pkg::PWR_NORMAL;
            next_port[p].rate_5g    = quiet[p] & rate[p];
            if (dis[p]) begin
                next_port[p].pwr_state = sltp_pkg::PWR_P1;
            end else if (quiet[p] && IN_DETECT_QUIET[p]) begin
                next_port[p].rx_term   = 1'b1;
                next_port[p].pwr_state = sltp_pkg::PWR_P0;
            end
            case (tx_st[p])
                sltp_pkg::SLTP_TX_IDLE: begin
                    next_idx[p] = 2'h0;
                    if (UTP_EN[p] && (quiet[p] || !IN_DETECT_QUIET[p]))
                        next_tx_st[p] = sltp_pkg::SLTP_TX_ALIGN;
                end
                sltp_pkg::SLTP_TX_ALIGN: begin
                    next_sym[p] = align_sym(idx[p]);
                    // A report can land on any symbol of the pattern, so it
                    // is held until the pattern in flight has gone out.
                    next_aseen[p] = aseen[p] | seen;
                    // Repeat until seen; once if bypass.
                    if (idx[p] == 2'h3 && (skip[p] || aseen[p] || seen))
                        next_tx_st[p] = sltp_pkg::SLTP_TX_SYNC;
                end
                sltp_pkg::SLTP_TX_SYNC: begin
                    next_sym[p] = sync_sym(idx[p]);
                    if (idx[p] == 2'h3)
                        next_tx_st[p] = sltp_pkg::SLTP_TX_USER;
                end
                sltp_pkg::SLTP_TX_USER: begin
                    next_user[p] = 1'b1;
                end
                default: next_tx_st[p] = sltp_pkg::SLTP_TX_IDLE;
            endcase
            if (!UTP_EN[p]) begin
                next_tx_st[p] = sltp_pkg::SLTP_TX_IDLE;
                next_user[p]  = 1'b0;
                next_aseen[p] = 1'b0;
            end
        end
    end

    // Read data multiplexer, registered.
    always_comb begin
        next_rdata = REG_RDATA;
        if (REG_RD) begin
            next_rdata = 32'h0000_0000;
            if (REG_ADDR == sltp_pkg::OFF_PORT_CTRL) begin
                next_rdata = {skip, rate, quiet, dis, SKIP_CTRL_LO};
            end else if (REG_ADDR == sltp_pkg::OFF_LANE_DIAG) begin
                next_rdata[sltp_pkg::POS_EXP +: 8] = exp_b[sel];
                next_rdata[sltp_pkg::POS_RCV +: 8] = rcv_b[sel];
                next_rdata[sltp_pkg::POS_CNT +: 8] = cnt[sel];
                next_rdata[sltp_pkg::POS_SEL +: 2] = sel;
                next_rdata[sltp_pkg::POS_SRC]      = src[sel];
            end
        end
    end

    // State registers.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            {skip, rate, quiet, dis} <= sltp_pkg::RST_CTRL_HI;
            sel       <= sltp_pkg::RST_SEL;
            cnt       <= '0;
            exp_b     <= '0;
            rcv_b     <= '0;
            src       <= '0;
            tx_st     <= '{default: sltp_pkg::SLTP_TX_IDLE};
            aseen     <= '0;
            idx       <= '0;
            PORT_CTRL <= '0;
            TX_SYM    <= '0;
            TX_USER   <= '0;
            REG_RDATA <= 32'h0000_0000;
        end else if (CE) begin
            dis       <= next_dis;
            quiet     <= next_quiet;
            rate      <= next_rate;
            skip      <= next_skip;
            sel       <= next_sel;
            cnt       <= next_cnt;
            exp_b     <= next_exp;
            rcv_b     <= next_rcv;
            src       <= next_src;
            tx_st     <= next_tx_st;
            idx       <= next_idx;
            aseen     <= next_aseen;
            PORT_CTRL <= next_port;
            TX_SYM    <= next_sym;
            TX_USER   <= next_user;
            REG_RDATA <= next_rdata;
        end
    end

    // Counter never passes its ceiling.
    // Saturation check.
    a_cnt_saturate: assert property (
        @(posedge CLK) disable iff (!RST_N)
        $past(CE) && $past(cnt[3]) == sltp_pkg::CNT_MAX &&
        $past(UTP_EN[3] | PRBS_EN[3]) |-> cnt[3] == sltp_pkg::CNT_MAX)
        else $error("error counter wrapped");

    a_cnt_clear: assert property (
        @(posedge CLK) disable iff (!RST_N)
        CE && !UTP_EN[3] && !PRBS_EN[3] |=> !CE || cnt[3] == 8'h00)
        else $error("counter not cleared on disable");

    a_dis_p1: assert property (
        @(posedge CLK) disable iff (!RST_N)
        CE && dis[2] |=> !CE || PORT_CTRL[2].pwr_state == sltp_pkg::PWR_P1)
        else $error("disabled port not in P1");

    a_rate_gate: assert property (
        @(posedge CLK) disable iff (!RST_N)
        CE && !quiet[1] |=> !CE || !PORT_CTRL[1].rate_5g)
        else $error("rate applied without quiet");

    // Bypass sends one alignment then sync.
    a_bypass_once: assert property (
        @(posedge CLK) disable iff (!RST_N)
        CE && skip[1] && UTP_EN[1] && tx_st[1] == sltp_pkg::SLTP_TX_ALIGN
        && idx[1] == 2'h3 |=> !CE || tx_st[1] != sltp_pkg::SLTP_TX_ALIGN)
        else $error("bypass repeated alignment");

    // Without bypass, alignment ends only after a report.
    a_align_wait: assert property (
        @(posedge CLK) disable iff (!RST_N)
        CE && !skip[0] && tx_st[0] == sltp_pkg::SLTP_TX_ALIGN &&
        !aseen[0] && !CHK[0].align_seen && !CHK[1].align_seen |=>
        !CE || tx_st[0] != sltp_pkg::SLTP_TX_SYNC)
        else $error("alignment ended without a report");

    a_quiet_hold: assert property (
        @(posedge CLK) disable iff (!RST_N)
        CE && quiet[0] |=> !CE || PORT_CTRL[0].hold_quiet)
        else $error("quiet hold missing");

    a_quiet_p0: assert property (
        @(posedge CLK) disable iff (!RST_N)
        CE && quiet[0] && !dis[0] && IN_DETECT_QUIET[0] |=>
        !CE || (PORT_CTRL[0].rx_term &&
        PORT_CTRL[0].pwr_state == sltp_pkg::PWR_P0))
        else $error("quiet port not terminated in P0");

    a_exp_cap: assert property (
        @(posedge CLK) disable iff (!RST_N)
        CE && UTP_EN[2] && CHK[2].utp_err |=>
        !CE || exp_b[2] == $past(CHK[2].exp_byte))
        else $error("expected byte not captured");

    a_rcv_cap: assert property (
        @(posedge CLK) disable iff (!RST_N)
        CE && UTP_EN[2] && CHK[2].utp_err |=>
        !CE || rcv_b[2] == $past(CHK[2].rcv_byte))
        else $error("received byte not captured");

    // Source flag shows the PRBS checker.
    a_src_prbs: assert property (
        @(posedge CLK) disable iff (!RST_N)
        CE && PRBS_EN[3] && !UTP_EN[3] |=> !CE || src[3])
        else $error("counter source not PRBS");
endmodule // sltp_ctrl

// *** hdl/sltp_pkg.sv ***
// Package for the serial lane test pattern control block.
// Assumes a single 50 MHz core clock and a simple register port.
package sltp_pkg;
    localparam int          NUM_PORTS       = 4;
    localparam int          NUM_LANES       = 4;
    localparam logic [11:0] OFF_PORT_CTRL   = 12'h0_234;
    localparam logic [11:0] OFF_LANE_DIAG   = 12'h0_238;
    localparam int          POS_DISABLE     = 16;
    localparam int          POS_QUIET       = 20;
    localparam int          POS_RATE        = 24;
    localparam int          POS_SKIP_ALIGN  = 28;
    localparam int          POS_EXP         = 0;
    localparam int          POS_RCV         = 8;
    localparam int          POS_CNT         = 16;
    localparam int          POS_SEL         = 24;
    localparam int          POS_SRC         = 30;
    localparam logic [15:0] RST_CTRL_HI     = 16'h0_000;
    localparam logic [1:0]  RST_SEL         = 2'h0;
    localparam logic [7:0]  CNT_MAX         = 8'hFF;
    // Symbol codes: 8b data plus K flag.
    localparam logic [8:0]  SYM_K28_5       = 9'h1_BC;
    localparam logic [8:0]  SYM_D3_2        = 9'h0_43;
    localparam logic [8:0]  SYM_D18_2       = 9'h0_52;
    localparam logic [8:0]  SYM_D13_2       = 9'h0_4D;
    localparam logic [8:0]  SYM_D17_1       = 9'h0_31;
    // Power states driven to the serdes.
    localparam logic [1:0]  PWR_P0          = 2'h0;
    localparam logic [1:0]  PWR_P1          = 2'h1;
    localparam logic [1:0]  PWR_NORMAL      = 2'h3;

    typedef enum logic [1:0] {
        SLTP_TX_IDLE  = 2'b00,
        SLTP_TX_ALIGN = 2'b01,
        SLTP_TX_SYNC  = 2'b10,
        SLTP_TX_USER  = 2'b11
    } sltp_tx_e;

    // Per-lane checker report.
    typedef struct packed {
        logic       utp_err;
        logic       prbs_err;
        logic [7:0] exp_byte;
        logic [7:0] rcv_byte;
        logic       align_seen;
    } sltp_chk_s;

    // Per-port control to the link state machine and serdes.
    typedef struct packed {
        logic       hold_quiet;
        logic       rx_term;
        logic [1:0] pwr_state;
        logic       rate_5g;
        logic       no_eios;
    } sltp_port_s;
endpackage

// *** dv/sltp_far_model.sv ***
// Far side model: loopback slave lane checkers for four lanes.
// Assumes the bench commands each error report; purely combinational.
`timescale 1ns/10ps
module sltp_far_model (
    input  wire logic [3:0][8:0]      tx_sym,
    input  wire logic [3:0]           listen,
    input  wire logic [3:0]           utp_hit,
    input  wire logic [3:0]           prbs_hit,
    input  wire logic [7:0]           exp_b,
    input  wire logic [7:0]           rcv_b,
    output sltp_pkg::sltp_chk_s [3:0] chk
);
    // Bytes are inverted outside a report so stale values never match.
    always_comb begin
        for (int l = 0; l < 4; l++) begin
            chk[l].utp_err    = utp_hit[l];
            chk[l].prbs_err   = prbs_hit[l];
            chk[l].exp_byte   = utp_hit[l] ? exp_b : ~exp_b;
            chk[l].rcv_byte   = utp_hit[l] ? rcv_b : ~rcv_b;
            // A listening checker sees the last alignment symbol.
            chk[l].align_seen = listen[l] &&
                                tx_sym[l] == sltp_pkg::SYM_D17_1;
        end
    end
endmodule // sltp_far_model

// *** dv/sltp_ctrl_test.sv ***
// Testbench for the lane test pattern control block.
// Assumes a 50 MHz clock and the strobe register port of the design.
`timescale 1ns/10ps
module sltp_ctrl_test;
    logic                          CLK = 0, RST_N = 0, REG_WR = 0, REG_RD = 0;
    logic [11:0]                   REG_ADDR = 0;
    logic [31:0]                   REG_WDATA = 0, REG_RDATA;
    logic [3:0]                    dq = 0, utp_en = 0, prbs_en = 0;
    logic [3:0]                    listen = 0, uhit = 0, phit = 0;
    logic [7:0]                    exp_b = 0, rcv_b = 0;
    sltp_pkg::sltp_chk_s [3:0]     chk;
    sltp_pkg::sltp_port_s [3:0]    pc;
    logic [3:0][8:0]               tx_sym;
    logic [3:0]                    tx_user;
    logic                          ce = 1;
    logic [8:0]                    seq [8];
    int                            miscompares = 0, check_count = 0, cyc = 0;

    // Clock and cycle ceiling.
    always #10 CLK = ~CLK;
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            miscompares++;
            give_verdict();
        end
    end

    sltp_ctrl u_dut (.CLK(CLK), .RST_N(RST_N), .CE(ce), .REG_WR(REG_WR),
        .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
        .REG_RDATA(REG_RDATA), .SKIP_CTRL_LO(16'h049C),
        .IN_DETECT_QUIET(dq), .UTP_EN(utp_en), .PRBS_EN(prbs_en),
        .CHK(chk), .PORT_CTRL(pc), .TX_SYM(tx_sym), .TX_USER(tx_user));
    sltp_far_model u_far (.tx_sym(tx_sym), .listen(listen), .utp_hit(uhit),
        .prbs_hit(phit), .exp_b(exp_b), .rcv_b(rcv_b), .chk(chk));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic cmp(string what, logic [31:0] e, logic [31:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic reg_wr(logic [11:0] a, logic [31:0] d);
        @(posedge CLK);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1;
        @(posedge CLK);
        REG_WR <= 0;
        repeat (2) @(posedge CLK);
    endtask

    task automatic reg_rd(logic [11:0] a, logic [31:0] e, string what);
        @(posedge CLK);
        REG_ADDR <= a;
        REG_RD <= 1;
        @(posedge CLK);
        REG_RD <= 0;
        @(posedge CLK);
        #1 cmp(what, e, REG_RDATA);
    endtask

    // Waits for an alignment start, then checks n symbols against seq.
    task automatic tx_run(int p, int n);
        // Step off the edge so a pending symbol update is not read stale.
        #1;
        for (int i = 0; i < 40 && tx_sym[p] !== seq[0]; i++)
            @(posedge CLK) #1;
        for (int i = 0; i < n; i++) begin
            cmp("tx_sym", {23'h0, seq[i]}, {23'h0, tx_sym[p]});
            @(posedge CLK) #1;
        end
    endtask

    task automatic hit(logic prbs, int l, logic [7:0] e, logic [7:0] r);
        @(posedge CLK);
        uhit <= prbs ? 4'h0 : 4'h1 << l;
        phit <= prbs ? 4'h1 << l : 4'h0;
        exp_b <= e;
        rcv_b <= r;
        @(posedge CLK);
        uhit <= 0;
        phit <= 0;
    endtask

    initial begin
        seq = '{sltp_pkg::SYM_D3_2, sltp_pkg::SYM_D18_2, sltp_pkg::SYM_D13_2,
                sltp_pkg::SYM_D17_1, sltp_pkg::SYM_K28_5, sltp_pkg::SYM_D3_2,
                sltp_pkg::SYM_D18_2, sltp_pkg::SYM_D13_2};
        repeat (20) @(posedge CLK);
        RST_N <= 1;
        // Reset values, unmapped place and read-only bits.
        reg_rd(12'h234, 32'h0000_049C, "ctrl reset");
        reg_rd(12'h238, 32'h0000_0000, "diag reset");
        reg_wr(12'h238, 32'hFFFF_FFFF);
        reg_rd(12'h238, 32'h0300_0000, "diag ro bits");
        reg_rd(12'h23C, 32'h0000_0000, "unmapped");
        // Port 0 quiet and fast, port 1 rate alone, port 2 disabled.
        @(posedge CLK) dq <= 4'hF;
        reg_wr(12'h234, 32'h2314_0000);
        reg_rd(12'h234, 32'h2314_049C, "ctrl readback");
        #1 cmp("p0 quiet", 32'h1, {31'h0, pc[0].hold_quiet});
        cmp("p0 term", 32'h1, {31'h0, pc[0].rx_term});
        cmp("p0 pwr", 32'(sltp_pkg::PWR_P0), 32'(pc[0].pwr_state));
        cmp("p0 rate", 32'h1, {31'h0, pc[0].rate_5g});
        cmp("p1 rate", 32'h0, {31'h0, pc[1].rate_5g});
        cmp("p1 quiet", 32'h0, {31'h0, pc[1].hold_quiet});
        cmp("p2 quiet", 32'h1, {31'h0, pc[2].hold_quiet});
        cmp("p2 pwr", 32'(sltp_pkg::PWR_P1), 32'(pc[2].pwr_state));
        cmp("p2 eios", 32'h1, {31'h0, pc[2].no_eios});
        // Port 1 with bypass: one alignment, one sync, then user data.
        @(posedge CLK) dq <= 4'h1;
        utp_en <= 4'h2;
        tx_run(1, 8);
        cmp("p1 user", 32'h1, {31'h0, tx_user[1]});
        // Port 0 quiet without bypass: alignment repeats until seen.
        @(posedge CLK) utp_en <= 4'h3;
        tx_run(0, 4);
        cmp("p0 repeat", {23'h0, seq[0]}, {23'h0, tx_sym[0]});
        @(posedge CLK) listen <= 4'h1;
        tx_run(0, 8);
        cmp("p0 user", 32'h1, {31'h0, tx_user[0]});
        // Lane 2 user pattern errors keep the latest bytes.
        @(posedge CLK) utp_en <= 4'h4;
        hit(0, 2, 8'hA5, 8'h5A);
        hit(0, 2, 8'h3C, 8'hC3);
        repeat (3) @(posedge CLK);
        reg_wr(12'h238, 32'h0200_0000);
        reg_rd(12'h238, 32'h0202_C33C, "lane2 diag");
        reg_rd(12'h238, 32'h0202_C33C, "lane2 hold");
        // Lane 3 PRBS errors saturate the counter.
        @(posedge CLK) prbs_en <= 4'h8;
        for (int i = 0; i < 258; i++)
            hit(1, 3, 8'h00, 8'h00);
        repeat (3) @(posedge CLK);
        reg_wr(12'h238, 32'h0300_0000);
        reg_rd(12'h238, 32'h43FF_0000, "lane3 prbs");
        // Turning checkers off clears counts and bytes.
        @(posedge CLK) prbs_en <= 4'h0;
        utp_en <= 4'h0;
        repeat (3) @(posedge CLK);
        reg_rd(12'h238, 32'h0300_0000, "lane3 clear");
        reg_wr(12'h238, 32'h0200_0000);
        reg_rd(12'h238, 32'h0200_0000, "lane2 clear");
        // Clock enable low freezes the lane select against a write.
        @(posedge CLK) ce <= 0;
        reg_wr(12'h238, 32'h0100_0000);
        @(posedge CLK) ce <= 1;
        reg_rd(12'h238, 32'h0200_0000, "ce freeze");
        give_verdict();
    end
endmodule // sltp_ctrl_test
